// ==== include/txbcp_pkg.sv ====
// constants shared by both ends of the transmit buffer command parser
package txbcp_pkg;
  // command A fields
  localparam int A_FIRST_BIT  = 13;
  localparam int A_LAST_BIT   = 12;
  localparam int A_SIZE_MSB   = 10;
  localparam int A_OFF_LSB    = 16;
  localparam int A_OFF_MSB    = 20;
  localparam int A_ALIGN_LSB  = 24;
  localparam int A_ALIGN_MSB  = 25;
  // command B fields
  localparam int B_TAG_LSB    = 16;
  localparam int B_NOCRC_BIT  = 13;
  localparam int B_NOPAD_BIT  = 12;
  localparam int B_LEN_MSB    = 10;
  // reserved bits 15:14 and 11 forced to zero
  localparam logic [31:0] RSVD_MASK = 32'h0000_c800;
  // alignment codes
  localparam logic [1:0] ALIGN_16 = 2'h1;
  localparam logic [1:0] ALIGN_32 = 2'h2;
  // word masks for 16- and 32-byte alignment
  localparam logic [10:0] MASK_16 = 11'h003;
  localparam logic [10:0] MASK_32 = 11'h007;
  // host apb register offsets
  localparam logic [7:0] REG_CMDA   = 8'h00;
  localparam logic [7:0] REG_CMDB   = 8'h04;
  localparam logic [7:0] REG_DATA   = 8'h08;
  localparam logic [7:0] REG_FILL   = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_CNT_LSB  = 16;
  // reset values
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
endpackage

// ==== include/txbcp_if.sv ====
// word link from the buffer writer to the command parser
`timescale 1ns/1ps
`default_nettype none
interface txbcp_if;
  logic [31:0] word;
  logic        valid;
  logic        ready;
  modport host (output word, output valid, input ready);
  modport dev  (input word, input valid, output ready);
endinterface
`default_nettype wire

// ==== logic/txbcp_host.sv ====
// buffer writer end: apb slave that feeds command and data words to the link
`timescale 1ns/1ps
`default_nettype none
module txbcp_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  txbcp_if.host            link
);
  logic [31:0] hold_word;
  logic        hold_valid;
  logic        filling;
  logic [10:0] dcnt;
  logic [1:0]  align;
  logic        busy;
  logic        push;
  logic        access;
  logic        mapped;
  logic [10:0] mask;
  logic        aligned;

  // decode
  assign access = psel & penable;
  assign mapped = (paddr == txbcp_pkg::REG_CMDA) | (paddr == txbcp_pkg::REG_CMDB)
                | (paddr == txbcp_pkg::REG_DATA) | (paddr == txbcp_pkg::REG_FILL)
                | (paddr == txbcp_pkg::REG_STATUS);
  assign busy   = hold_valid | filling;
  // pushing writes stall until the previous word has left, so nothing is lost
  assign push   = pwrite & mapped & (paddr != txbcp_pkg::REG_STATUS);
  assign pready = access & (~push | ~busy);
  assign pslverr = access & ~mapped;
  assign link.word  = hold_word;
  assign link.valid = hold_valid;

  // filler words until the data region meets the chosen boundary
  always_comb begin
    case (align)
      txbcp_pkg::ALIGN_16: mask = txbcp_pkg::MASK_16;
      txbcp_pkg::ALIGN_32: mask = txbcp_pkg::MASK_32;
      default:             mask = 11'h000;
    endcase
  end
  assign aligned = (dcnt & mask) == 11'h000;

  // holding register toward the link
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_word  <= txbcp_pkg::WORD_RST;
      hold_valid <= 1'b0;
    end else if (hold_valid) begin
      if (link.ready) begin
        hold_valid <= 1'b0;
      end
    end else if (pready & push & (paddr == txbcp_pkg::REG_CMDA)) begin
      hold_word  <= pwdata & ~txbcp_pkg::RSVD_MASK;
      hold_valid <= 1'b1;
    end else if (pready & push & (paddr == txbcp_pkg::REG_CMDB)) begin
      // tag and length pass as software gives them
      hold_word  <= pwdata & ~txbcp_pkg::RSVD_MASK;
      hold_valid <= 1'b1;
    end else if (pready & push & (paddr == txbcp_pkg::REG_DATA)) begin
      hold_word  <= pwdata;
      hold_valid <= 1'b1;
    end else if (filling & ~aligned) begin
      hold_word  <= txbcp_pkg::WORD_RST;
      hold_valid <= 1'b1;
    end
  end

  // fill request and data plus filler word count since the last command A
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filling <= 1'b0;
      dcnt    <= 11'h000;
      align   <= 2'h0;
    end else begin
      if (pready & push & (paddr == txbcp_pkg::REG_CMDA)) begin
        dcnt  <= 11'h000;
        align <= pwdata[txbcp_pkg::A_ALIGN_MSB:txbcp_pkg::A_ALIGN_LSB];
      end else if (~hold_valid & ((pready & push & (paddr == txbcp_pkg::REG_DATA))
                                  | (filling & ~aligned))) begin
        dcnt <= dcnt + 11'h001;
      end
      if (pready & push & (paddr == txbcp_pkg::REG_FILL)) begin
        filling <= 1'b1;
      end else if (filling & ~hold_valid & aligned) begin
        filling <= 1'b0;
      end
    end
  end

  // read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= (paddr == txbcp_pkg::REG_STATUS)
              ? {5'h00, dcnt, 15'h0000, busy} : 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// ==== logic/txbcp_device.sv ====
// command parser end: strips commands, offsets and filler, streams bytes to the mac
`timescale 1ns/1ps
`default_nettype none
module txbcp_device (
  input  wire logic        pclk,
  input  wire logic        presetn,
  txbcp_if.dev             link,
  output logic      [7:0]  mac_data,
  output logic             mac_valid,
  output logic             mac_last,
  input  wire logic        mac_ready,
  output logic             stat_valid,
  output logic      [15:0] stat_tag,
  output logic             stat_no_crc,
  output logic             stat_no_pad,
  output logic             transmit_error_flag,
  input  wire logic        err_clear
);
  typedef enum logic [4:0] {
    ST_CMDA  = 5'b00001,
    ST_CMDB  = 5'b00010,
    ST_WORDS = 5'b00100,
    ST_EMIT  = 5'b01000,
    ST_DONE  = 5'b10000
  } txbcp_state_t;

  txbcp_state_t state;
  logic        first_segment_flag;
  logic        last_seg;
  logic [1:0]  off_lane;
  logic [2:0]  skip_w;
  logic [10:0] rem;
  logic [10:0] end_w;
  logic [10:0] wcnt;
  logic [11:0] sum;
  logic [10:0] pkt_len;
  logic [15:0] tag;
  logic        no_crc;
  logic        no_pad;
  logic [31:0] word_q;
  logic [2:0]  blw;
  logic        take;
  logic        load;
  logic        step;
  logic [4:0]  a_off;
  logic [10:0] a_size;
  logic [11:0] a_bytes;
  logic [10:0] a_words;
  logic [10:0] a_mask;
  logic [10:0] next_end;
  logic [1:0]  start_lane;

  // command A decode, done on the word as it arrives
  assign a_off   = link.word[txbcp_pkg::A_OFF_MSB:txbcp_pkg::A_OFF_LSB];
  assign a_size  = link.word[txbcp_pkg::A_SIZE_MSB:0];
  assign a_bytes = {1'b0, a_size} + {7'h00, a_off};
  assign a_words = {1'b0, a_bytes[11:2]} + {10'h000, a_bytes[1] | a_bytes[0]};
  always_comb begin
    case (link.word[txbcp_pkg::A_ALIGN_MSB:txbcp_pkg::A_ALIGN_LSB])
      txbcp_pkg::ALIGN_16: a_mask = txbcp_pkg::MASK_16;
      txbcp_pkg::ALIGN_32: a_mask = txbcp_pkg::MASK_32;
      default:             a_mask = 11'h000; // reserved code acts as 4-byte
    endcase
  end
  // words of the buffer after the commands, filler included
  assign next_end = (a_words + a_mask) & ~a_mask;

  // link handshake; a word is only taken while no byte is pending
  assign link.ready = (state == ST_CMDA) | (state == ST_CMDB)
                    | ((state == ST_WORDS) & (wcnt != end_w));
  assign take = link.ready & link.valid;
  // word carries payload once the offset words are past
  assign load = (state == ST_WORDS) & take & (wcnt >= {8'h00, skip_w})
              & (rem != 11'h000);
  assign start_lane = (wcnt == {8'h00, skip_w}) ? off_lane : 2'h0;
  assign step = (state == ST_EMIT) & mac_ready;

  // byte stream outputs; low byte of the shifted word is the current byte
  assign mac_data  = word_q[7:0];
  assign mac_valid = state == ST_EMIT;
  assign mac_last  = (state == ST_EMIT) & last_seg & (rem == 11'h001);

  // sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_CMDA;
    end else begin
      case (state)
        ST_CMDA: begin
          if (take) begin
            // command B follows only a first segment
            state <= link.word[txbcp_pkg::A_FIRST_BIT] ? ST_CMDB : ST_WORDS;
          end
        end
        ST_CMDB: begin
          if (take) begin
            state <= ST_WORDS;
          end
        end
        ST_WORDS: begin
          if (wcnt == end_w) begin
            state <= ST_DONE;
          end else if (load) begin
            state <= ST_EMIT;
          end
        end
        ST_EMIT: begin
          if (step & ((rem == 11'h001) | (blw == 3'h1))) begin
            state <= ST_WORDS;
          end
        end
        ST_DONE: state <= ST_CMDA;
        default: state <= ST_CMDA;
      endcase
    end
  end

  // per-buffer fields from command A
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_segment_flag <= 1'b0;
      last_seg <= 1'b0;
      off_lane <= 2'h0;
      skip_w   <= 3'h0;
      end_w    <= 11'h000;
    end else if ((state == ST_CMDA) & take) begin
      first_segment_flag <= link.word[txbcp_pkg::A_FIRST_BIT];
      last_seg <= link.word[txbcp_pkg::A_LAST_BIT];
      off_lane <= a_off[1:0];
      skip_w   <= a_off[4:2];
      end_w    <= next_end;
    end
  end

  // running byte total of the packet's buffers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sum <= 12'h000;
    end else if ((state == ST_CMDA) & take) begin
      // a first segment restarts the total
      sum <= (link.word[txbcp_pkg::A_FIRST_BIT] ? 12'h000 : sum)
           + {1'b0, a_size};
    end
  end

  // packet fields from command B
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tag     <= 16'h0000;
      no_crc  <= 1'b0;
      no_pad  <= 1'b0;
      pkt_len <= 11'h000;
    end else if ((state == ST_CMDB) & take & first_segment_flag) begin
      // command B fields only ever belong to a first segment
      tag     <= link.word[31:txbcp_pkg::B_TAG_LSB];
      no_crc  <= link.word[txbcp_pkg::B_NOCRC_BIT];
      no_pad  <= link.word[txbcp_pkg::B_NOPAD_BIT];
      pkt_len <= link.word[txbcp_pkg::B_LEN_MSB:0];
    end
  end

  // word counter over the data region: offset, payload and filler words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wcnt <= 11'h000;
    end else if (state == ST_CMDA) begin
      wcnt <= 11'h000;
    end else if ((state == ST_WORDS) & take) begin
      wcnt <= wcnt + 11'h001;
    end
  end

  // payload bytes left in the buffer; the count, not the word, ends it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rem <= 11'h000;
    end else if ((state == ST_CMDA) & take) begin
      rem <= a_size;
    end else if (step) begin
      rem <= rem - 11'h001;
    end
  end

  // byte unpacking: shift so the current byte sits in the low lane
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_q <= txbcp_pkg::WORD_RST;
      blw    <= 3'h0;
    end else if (load) begin
      word_q <= link.word >> {start_lane, 3'h0};
      blw    <= 3'h4 - {1'b0, start_lane};
    end else if (step) begin
      word_q <= {8'h00, word_q[31:8]};
      blw    <= blw - 3'h1;
    end
  end

  // status at the end of the final buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_valid  <= 1'b0;
      stat_tag    <= 16'h0000;
      stat_no_crc <= 1'b0;
      stat_no_pad <= 1'b0;
    end else begin
      stat_valid <= (state == ST_DONE) & last_seg;
      if ((state == ST_DONE) & last_seg) begin
        stat_tag    <= tag;
        // pad suppression keeps the crc on regardless of the crc bit
        stat_no_crc <= no_crc & ~no_pad;
        stat_no_pad <= no_pad;
      end
    end
  end

  // sticky error; a mismatch in the clearing cycle still sets it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_error_flag <= 1'b0;
    end else if ((state == ST_DONE) & last_seg & (sum != {1'b0, pkt_len})) begin
      transmit_error_flag <= 1'b1;
    end else if (err_clear) begin
      transmit_error_flag <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/txbcp_chk.sv ====
// checker for the parser link, mac byte stream and packet status
`timescale 1ns/1ps
`default_nettype none
module txbcp_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [31:0] word,
  input wire logic        valid,
  input wire logic        ready,
  input wire logic [7:0]  mac_data,
  input wire logic        mac_valid,
  input wire logic        mac_last,
  input wire logic        mac_ready,
  input wire logic        stat_valid,
  input wire logic        stat_no_crc,
  input wire logic        stat_no_pad,
  input wire logic        transmit_error_flag,
  input wire logic        err_clear
);
  // one clock domain, so clocking and reset are given once
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // a word offered but not yet taken
  sequence s_word_wait;
    valid && !ready;
  endsequence
  // the closing byte of a packet handed over
  sequence s_last_taken;
    mac_valid && mac_ready && mac_last;
  endsequence
  a_word_held: assert property (s_word_wait |=> valid && $stable(word))
    else $error("link word changed before it was taken");
  a_byte_held: assert property (mac_valid && !mac_ready |=> mac_valid && $stable(mac_data))
    else $error("mac byte changed before it was taken");
  a_ready_drop: assert property (mac_valid |-> !ready)
    else $error("link accepted words while bytes were pending");
  a_end_quiet: assert property (s_last_taken |=> !mac_valid [*2])
    else $error("bytes offered right after the closing byte");
  a_stat_pulse: assert property (stat_valid |=> !stat_valid)
    else $error("status strobe longer than one cycle");
  a_crc_forced: assert property (stat_valid && stat_no_pad |-> !stat_no_crc)
    else $error("crc dropped while padding was off");
  a_err_sticky: assert property (transmit_error_flag && !err_clear |=> transmit_error_flag)
    else $error("error flag fell without a clear");
  a_err_cause: assert property ($rose(transmit_error_flag) |-> stat_valid || $past(stat_valid))
    else $error("error flag rose away from a packet end");
endmodule
`default_nettype wire

// ==== testbench/tx_buffer_command_parser_tb_top.sv ====
// bench: apb writer feeding the parser, mac byte capture and checks
`timescale 1ns/1ps
`default_nettype none
module tx_buffer_command_parser_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, mac_data;
  logic [31:0] pwdata, prdata, r;
  logic        mac_valid, mac_last, mac_ready, stat_valid, e;
  logic [15:0] stat_tag;
  logic        stat_no_crc, stat_no_pad, transmit_error_flag, err_clear;
  int          n_fail, comparisons, n_stat, n_done, last_at, cyc;
  logic [7:0]  got[$], exp[$];
  txbcp_if link_i();
  txbcp_host u_txbcp_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link_i));
  txbcp_device u_txbcp_device (.pclk(pclk), .presetn(presetn), .link(link_i),
    .mac_data(mac_data), .mac_valid(mac_valid), .mac_last(mac_last), .mac_ready(mac_ready),
    .stat_valid(stat_valid), .stat_tag(stat_tag), .stat_no_crc(stat_no_crc),
    .stat_no_pad(stat_no_pad), .transmit_error_flag(transmit_error_flag),
    .err_clear(err_clear));
  txbcp_chk u_txbcp_chk (.pclk(pclk), .presetn(presetn), .word(link_i.word),
    .valid(link_i.valid), .ready(link_i.ready), .mac_data(mac_data), .mac_valid(mac_valid),
    .mac_last(mac_last), .mac_ready(mac_ready), .stat_valid(stat_valid),
    .stat_no_crc(stat_no_crc), .stat_no_pad(stat_no_pad),
    .transmit_error_flag(transmit_error_flag), .err_clear(err_clear));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // mac stalls one cycle in four so held bytes get exercised
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    mac_ready <= (cyc % 4) != 3;
  end
  // capture every byte taken and count status strobes
  always @(posedge pclk) begin
    if (mac_valid && mac_ready) begin
      if (mac_last) last_at <= got.size() + 1;
      got.push_back(mac_data);
    end
    if (stat_valid) n_stat <= n_stat + 1;
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] want, input string msg);
    comparisons++;
    if (seen !== want) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, seen, want);
    end
  endtask
  // one apb transfer; waits on pready under a bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 1000);
    if (pready !== 1'b1) begin
      n_fail++;
      report_and_stop();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, a, d, rd, er);
  endtask
  function automatic logic [31:0] mk_a(logic f, logic l, logic [1:0] al, logic [4:0] off,
                                       logic [10:0] sz);
    return {6'h00, al, 3'h0, off, 2'h0, f, l, 1'b0, sz};
  endfunction
  function automatic logic [31:0] mk_b(logic [15:0] tag, logic nc, logic np, logic [10:0] len);
    return {tag, 2'h0, nc, np, 1'b0, len};
  endfunction
  // stream byte p of a buffer is base+p, so expectations follow from offset and size
  task automatic send_buf(input logic [31:0] ca, input logic [31:0] cb, input logic [7:0] base);
    int          off;
    int          nw;
    logic [31:0] w;
    off = int'(ca[20:16]);
    nw = (off + int'(ca[10:0]) + 3) / 4;
    wr(txbcp_pkg::REG_CMDA, ca);
    if (ca[13]) wr(txbcp_pkg::REG_CMDB, cb);
    for (int i = 0; i < nw; i++) begin
      for (int j = 0; j < 4; j++) w[8*j+:8] = base + 8'(4 * i + j);
      wr(txbcp_pkg::REG_DATA, w);
    end
    for (int p = off; p < off + int'(ca[10:0]); p++) exp.push_back(base + 8'(p));
    wr(txbcp_pkg::REG_FILL, 32'h0000_0000);
  endtask
  task automatic finish_pkt(input logic [15:0] tag, input logic nc, input logic np,
                            input logic er);
    int n;
    n = 0;
    while (n_stat == n_done && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    if (n_stat == n_done) begin
      n_fail++;
      report_and_stop();
    end
    n_done = n_stat;
    @(posedge pclk);
    chk(32'(got.size()), 32'(exp.size()), "byte count");
    for (int i = 0; i < exp.size(); i++) chk({24'h0, got[i]}, {24'h0, exp[i]}, "byte");
    chk(32'(last_at), 32'(exp.size()), "last marker");
    chk({16'h0, stat_tag}, {16'h0, tag}, "status tag");
    chk({31'h0, stat_no_crc}, {31'h0, nc & ~np}, "crc off");
    chk({31'h0, stat_no_pad}, {31'h0, np}, "pad off");
    chk({31'h0, transmit_error_flag}, {31'h0, er}, "error flag");
    got.delete();
    exp.delete();
    last_at = 0;
  endtask
  // one buffer: word skip plus lane 1, 16-byte end fill, crc off
  task automatic sc_single();
    send_buf(mk_a(1'b1, 1'b1, 2'h1, 5'h05, 11'h006),
             mk_b(16'h1234, 1'b1, 1'b0, 11'h006), 8'h10);
    finish_pkt(16'h1234, 1'b1, 1'b0, 1'b0);
    apb(1'b0, txbcp_pkg::REG_STATUS, 32'h0, r, e);
    chk({21'h0, r[26:16]}, 32'h0000_0004, "words incl fill");
    chk({31'h0, r[0]}, 32'h0, "busy");
  endtask
  // short first buffer, four-byte middle buffer, final at offset 31 with 32-byte fill
  task automatic sc_multi();
    send_buf(mk_a(1'b1, 1'b0, 2'h0, 5'h02, 11'h003),
             mk_b(16'hbeef, 1'b1, 1'b1, 11'h00c), 8'h40);
    send_buf(mk_a(1'b0, 1'b0, 2'h1, 5'h00, 11'h004), 32'h0, 8'h60);
    send_buf(mk_a(1'b0, 1'b1, 2'h2, 5'h1f, 11'h005), 32'h0, 8'h80);
    finish_pkt(16'hbeef, 1'b1, 1'b1, 1'b0);
  endtask
  // every lane code for the first byte
  task automatic sc_lanes();
    for (int k = 0; k < 4; k++) begin
      send_buf(mk_a(1'b1, 1'b1, 2'h0, 5'(k), 11'h001),
               mk_b(16'(k), 1'b0, 1'b0, 11'h001), 8'(k * 16));
      finish_pkt(16'(k), 1'b0, 1'b0, 1'b0);
    end
  endtask
  // declared length disagrees with buffer sizes, then clear
  task automatic sc_mismatch();
    send_buf(mk_a(1'b1, 1'b1, 2'h0, 5'h00, 11'h002),
             mk_b(16'h0bad, 1'b0, 1'b1, 11'h003), 8'h20);
    finish_pkt(16'h0bad, 1'b0, 1'b1, 1'b1);
    err_clear <= 1'b1;
    @(posedge pclk);
    err_clear <= 1'b0;
    @(posedge pclk);
    @(posedge pclk);
    chk({31'h0, transmit_error_flag}, 32'h0, "flag after clear");
  endtask
  // unmapped address is refused
  task automatic sc_unmapped();
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk({31'h0, e}, 32'h1, "unmapped err");
    chk(r, 32'h0, "unmapped data");
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    err_clear = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    sc_single();
    sc_multi();
    sc_lanes();
    sc_mismatch();
    sc_unmapped();
    report_and_stop();
  end
endmodule
`default_nettype wire
